// ===== logic/cbx_pkg.sv
// Purpose: constants and types for the bit-transfer and control execution unit
// Assumes: 8-bit data path, 32 working registers, 16-bit pointers and addresses
// Notes:   opcode encodings are local to this unit, not the instruction word format
package cbx_pkg;

  // ==========================================
  // operation codes presented by the decoder
  typedef enum logic [5:0] {
    CBX_NOP       = 6'h00,
    CBX_ROL       = 6'h01,
    CBX_ROR       = 6'h02,
    CBX_ASR       = 6'h03,
    CBX_SWAP      = 6'h04,
    CBX_FSET      = 6'h05,
    CBX_FCLR      = 6'h06,
    CBX_BST       = 6'h07,
    CBX_BLD       = 6'h08,
    CBX_MOV       = 6'h09,
    CBX_REGISTER_PAIR_COPY      = 6'h0a,
    CBX_LDI       = 6'h0b,
    CBX_LD_PTR    = 6'h0c,
    CBX_LD_INC    = 6'h0d,
    CBX_LD_DEC    = 6'h0e,
    CBX_LD_DISP   = 6'h0f,
    CBX_LD_DIR    = 6'h10,
    CBX_ST_PTR    = 6'h11,
    CBX_ST_INC    = 6'h12,
    CBX_ST_DEC    = 6'h13,
    CBX_ST_DISP   = 6'h14,
    CBX_ST_DIR    = 6'h15,
    CBX_PM_R0     = 6'h16,
    CBX_PM_RD     = 6'h17,
    CBX_PM_INC    = 6'h18,
    CBX_IN        = 6'h19,
    CBX_OUT       = 6'h1a,
    CBX_PUSH      = 6'h1b,
    CBX_POP       = 6'h1c,
    CBX_SLEEP     = 6'h1d,
    CBX_WDR       = 6'h1e,
    CBX_BREAK     = 6'h1f
  } cbx_op_t;

  // ==========================================
  // sequencer states
  typedef enum logic [1:0] {
    CBX_S_IDLE = 2'b00,
    CBX_S_MEM  = 2'b01,
    CBX_S_PM1  = 2'b10,
    CBX_S_PM2  = 2'b11
  } cbx_state_t;

  // ==========================================
  // status flag positions
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;
  localparam int unsigned FLG_T = 6;
  localparam int unsigned FLG_I = 7;

  // pointer low-register indices: X=26, Y=28, Z=30
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  localparam logic [1:0] PTR_SEL_X = 2'h0;
  localparam logic [1:0] PTR_SEL_Y = 2'h1;
  localparam logic [1:0] PTR_SEL_Z = 2'h2;

  // reset values
  localparam logic [7:0]  STATUS_REGISTER_RST = 8'h00;
  localparam logic [15:0] SP_RST   = 16'h04ff;
  localparam logic [7:0]  REG_RST  = 8'h00;

endpackage

// ===== logic/cbx_exec.sv
// Purpose: executes rotate/shift, bit transfer, flag, move, load/store, stack and control ops
// Assumes: decoder presents one op with op_valid while busy is low; data memory answers during its strobe, flash the cycle after
// Notes:   arithmetic, logic and branch ops live elsewhere
// How it works
// - rotate left through carry: C into bit0, bit7 into C, Z C N V updated
// - rotate right through carry: C into bit7, bit0 into C, Z C N V updated
// - arithmetic right shift keeps bit7, bit0 into C, Z N V updated
// - bit store copies chosen register bit into T, nothing else changes
// - bit load copies T into chosen register bit, flags untouched
// - one-cycle set or clear of any single status flag by index
// - post-increment load reads at pointer then bumps pointer, two cycles
// - pre-decrement load drops pointer first then reads, two cycles
// - displacement load reads Y or Z plus offset, pointer kept, two cycles
// - post-increment store writes at pointer then bumps pointer, two cycles
// - pre-decrement store drops pointer first then writes, two cycles
// - displacement store writes Y or Z plus offset, pointer kept, two cycles
// - direct load reads absolute address into register in two cycles
// - direct store writes register to absolute address in two cycles
// - program-memory read via Z in three cycles; R0, any Rd, or Z post-increment
// - push writes register onto stack in two cycles, no flags
// - pop reads stack top into register in two cycles, no flags
// - sleep takes one cycle and pulses the sleep controller
// - watchdog restart takes one cycle and pulses the watchdog
// - break only signals the debug unit
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module cbx_exec #(
  parameter int unsigned NREG = 32
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // decoded operation
  input  wire logic        op_valid,
  input  wire logic [5:0]  op_code,
  input  wire logic [4:0]  op_rd,
  input  wire logic [4:0]  op_rr,
  input  wire logic [2:0]  op_bit,
  input  wire logic [1:0]  op_ptr,
  input  wire logic [5:0]  op_disp,
  input  wire logic [15:0] op_addr,
  input  wire logic [7:0]  op_imm,
  // data memory / io space
  output logic             dm_rd,
  output logic             dm_wr,
  output logic [15:0]      dm_addr,
  output logic [7:0]       dm_wdata,
  input  wire logic [7:0]  dm_rdata,
  // program memory
  output logic             pm_rd,
  output logic [15:0]      pm_addr,
  input  wire logic [7:0]  pm_rdata,
  // control pulses and state
  output logic             busy,
  output logic             sleep_req,
  output logic             wdt_restart,
  output logic             dbg_break,
  output logic [7:0]       status_register,
  output logic [15:0]      stack_ptr
);

  initial begin
    if (NREG != 32) $error("cbx_exec: pointer pairs need exactly 32 registers");
  end

  // ==========================================
  // state
  logic [7:0]  regs_r [NREG];
  logic [7:0]  regs_nxt [NREG];
  logic [7:0]  status_register_r, status_register_nxt;
  logic [15:0] sp_r, sp_nxt;
  cbx_pkg::cbx_state_t st_r, st_nxt;
  logic [4:0]  dst_r, dst_nxt;
  logic        ldm_r, ldm_nxt;
  logic        dm_rd_r, dm_rd_nxt;
  logic        dm_wr_r, dm_wr_nxt;
  logic [15:0] dm_addr_r, dm_addr_nxt;
  logic [7:0]  dm_wdata_r, dm_wdata_nxt;
  logic        pm_rd_r, pm_rd_nxt;
  logic [15:0] pm_addr_r, pm_addr_nxt;
  logic        slp_r, slp_nxt;
  logic        wdr_r, wdr_nxt;
  logic        brk_r, brk_nxt;

  // ==========================================
  // combinational helpers
  logic [4:0]  plo;
  logic [15:0] pval;
  logic [7:0]  a;
  logic [7:0]  res;

  always_comb begin
    plo = cbx_pkg::PTR_X_LO;
    if (op_ptr == cbx_pkg::PTR_SEL_Y) plo = cbx_pkg::PTR_Y_LO;
    if (op_ptr == cbx_pkg::PTR_SEL_Z) plo = cbx_pkg::PTR_Z_LO;
    pval = {regs_r[plo + 5'd1], regs_r[plo]};
    a    = regs_r[op_rd];
  end

  always_comb begin
    regs_nxt     = regs_r;
    status_register_nxt     = status_register_r;
    sp_nxt       = sp_r;
    st_nxt       = st_r;
    dst_nxt      = dst_r;
    ldm_nxt      = 1'b0;
    dm_rd_nxt    = 1'b0;
    dm_wr_nxt    = 1'b0;
    dm_addr_nxt  = dm_addr_r;
    dm_wdata_nxt = dm_wdata_r;
    pm_rd_nxt    = 1'b0;
    pm_addr_nxt  = pm_addr_r;
    slp_nxt      = 1'b0;
    wdr_nxt      = 1'b0;
    brk_nxt      = 1'b0;
    res          = 8'h00;
    case (st_r)
      cbx_pkg::CBX_S_IDLE: begin
        if (op_valid) begin
          case (cbx_pkg::cbx_op_t'(op_code))
            cbx_pkg::CBX_ROL, cbx_pkg::CBX_ROR, cbx_pkg::CBX_ASR: begin
              if (op_code == cbx_pkg::CBX_ROL) begin
                res = {a[6:0], status_register_r[cbx_pkg::FLG_C]};
                status_register_nxt[cbx_pkg::FLG_C] = a[7];
              end else if (op_code == cbx_pkg::CBX_ROR) begin
                res = {status_register_r[cbx_pkg::FLG_C], a[7:1]};
                status_register_nxt[cbx_pkg::FLG_C] = a[0];
              end else begin
                res = {a[7], a[7:1]};
                status_register_nxt[cbx_pkg::FLG_C] = a[0];
              end
              regs_nxt[op_rd] = res;
              status_register_nxt[cbx_pkg::FLG_Z] = (res == 8'h00);
              status_register_nxt[cbx_pkg::FLG_N] = res[7];
              status_register_nxt[cbx_pkg::FLG_V] = res[7] ^ status_register_nxt[cbx_pkg::FLG_C];
              status_register_nxt[cbx_pkg::FLG_S] = status_register_nxt[cbx_pkg::FLG_N] ^ status_register_nxt[cbx_pkg::FLG_V];
            end
            cbx_pkg::CBX_SWAP: regs_nxt[op_rd] = {a[3:0], a[7:4]};
            cbx_pkg::CBX_FSET: status_register_nxt[op_bit] = 1'b1;
            cbx_pkg::CBX_FCLR: status_register_nxt[op_bit] = 1'b0;
            cbx_pkg::CBX_BST:  status_register_nxt[cbx_pkg::FLG_T] = regs_r[op_rr][op_bit];
            cbx_pkg::CBX_BLD:  regs_nxt[op_rd][op_bit] = status_register_r[cbx_pkg::FLG_T];
            cbx_pkg::CBX_MOV:  regs_nxt[op_rd] = regs_r[op_rr];
            cbx_pkg::CBX_REGISTER_PAIR_COPY: begin
              regs_nxt[{op_rd[4:1], 1'b0}] = regs_r[{op_rr[4:1], 1'b0}];
              regs_nxt[{op_rd[4:1], 1'b1}] = regs_r[{op_rr[4:1], 1'b1}];
            end
            cbx_pkg::CBX_LDI:  regs_nxt[op_rd] = op_imm;
            cbx_pkg::CBX_IN: begin
              // port read answers next cycle; held in the memory state
              dm_rd_nxt   = 1'b1;
              dm_addr_nxt = op_addr;
              dst_nxt     = op_rd;
              ldm_nxt     = 1'b1;
              st_nxt      = cbx_pkg::CBX_S_MEM;
            end
            cbx_pkg::CBX_OUT: begin
              dm_wr_nxt    = 1'b1;
              dm_addr_nxt  = op_addr;
              dm_wdata_nxt = regs_r[op_rr];
            end
            cbx_pkg::CBX_LD_PTR, cbx_pkg::CBX_LD_INC, cbx_pkg::CBX_LD_DEC,
            cbx_pkg::CBX_LD_DISP, cbx_pkg::CBX_LD_DIR, cbx_pkg::CBX_POP: begin
              dm_rd_nxt = 1'b1;
              dst_nxt   = op_rd;
              ldm_nxt   = 1'b1;
              st_nxt    = cbx_pkg::CBX_S_MEM;
              dm_addr_nxt = pval;
              if (op_code == cbx_pkg::CBX_LD_INC)
                {regs_nxt[plo + 5'd1], regs_nxt[plo]} = pval + 16'h0001;
              if (op_code == cbx_pkg::CBX_LD_DEC) begin
                dm_addr_nxt = pval - 16'h0001;
                {regs_nxt[plo + 5'd1], regs_nxt[plo]} = pval - 16'h0001;
              end
              if (op_code == cbx_pkg::CBX_LD_DISP)
                dm_addr_nxt = pval + {10'h000, op_disp};
              if (op_code == cbx_pkg::CBX_LD_DIR)
                dm_addr_nxt = op_addr;
              if (op_code == cbx_pkg::CBX_POP) begin
                dm_addr_nxt = sp_r + 16'h0001;
                sp_nxt      = sp_r + 16'h0001;
              end
            end
            cbx_pkg::CBX_ST_PTR, cbx_pkg::CBX_ST_INC, cbx_pkg::CBX_ST_DEC,
            cbx_pkg::CBX_ST_DISP, cbx_pkg::CBX_ST_DIR, cbx_pkg::CBX_PUSH: begin
              // second cycle is a stall so stores keep their two-cycle timing
              dm_wr_nxt    = 1'b1;
              dm_wdata_nxt = regs_r[op_rr];
              st_nxt       = cbx_pkg::CBX_S_MEM;
              dm_addr_nxt  = pval;
              if (op_code == cbx_pkg::CBX_ST_INC)
                {regs_nxt[plo + 5'd1], regs_nxt[plo]} = pval + 16'h0001;
              if (op_code == cbx_pkg::CBX_ST_DEC) begin
                dm_addr_nxt = pval - 16'h0001;
                {regs_nxt[plo + 5'd1], regs_nxt[plo]} = pval - 16'h0001;
              end
              if (op_code == cbx_pkg::CBX_ST_DISP)
                dm_addr_nxt = pval + {10'h000, op_disp};
              if (op_code == cbx_pkg::CBX_ST_DIR)
                dm_addr_nxt = op_addr;
              if (op_code == cbx_pkg::CBX_PUSH) begin
                dm_addr_nxt = sp_r;
                sp_nxt      = sp_r - 16'h0001;
              end
            end
            cbx_pkg::CBX_PM_R0, cbx_pkg::CBX_PM_RD, cbx_pkg::CBX_PM_INC: begin
              pm_rd_nxt   = 1'b1;
              pm_addr_nxt = {regs_r[cbx_pkg::PTR_Z_LO + 5'd1], regs_r[cbx_pkg::PTR_Z_LO]};
              dst_nxt     = (op_code == cbx_pkg::CBX_PM_R0) ? 5'd0 : op_rd;
              st_nxt      = cbx_pkg::CBX_S_PM1;
              if (op_code == cbx_pkg::CBX_PM_INC)
                {regs_nxt[cbx_pkg::PTR_Z_LO + 5'd1], regs_nxt[cbx_pkg::PTR_Z_LO]} =
                  pm_addr_nxt + 16'h0001;
            end
            cbx_pkg::CBX_SLEEP: slp_nxt = 1'b1;
            cbx_pkg::CBX_WDR:   wdr_nxt = 1'b1;
            cbx_pkg::CBX_BREAK: brk_nxt = 1'b1;
            default: ;
          endcase
        end
      end
      cbx_pkg::CBX_S_MEM: begin
        if (ldm_r) regs_nxt[dst_r] = dm_rdata;
        st_nxt = cbx_pkg::CBX_S_IDLE;
      end
      cbx_pkg::CBX_S_PM1: st_nxt = cbx_pkg::CBX_S_PM2;
      cbx_pkg::CBX_S_PM2: begin
        // flash data captured one cycle late, giving the third cycle
        regs_nxt[dst_r] = pm_rdata;
        st_nxt = cbx_pkg::CBX_S_IDLE;
      end
      default: st_nxt = cbx_pkg::CBX_S_IDLE;
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < NREG; i++) regs_r[i] <= cbx_pkg::REG_RST;
      status_register_r     <= cbx_pkg::STATUS_REGISTER_RST;
      sp_r       <= cbx_pkg::SP_RST;
      st_r       <= cbx_pkg::CBX_S_IDLE;
      dst_r      <= 5'd0;
      ldm_r      <= 1'b0;
      dm_rd_r    <= 1'b0;
      dm_wr_r    <= 1'b0;
      dm_addr_r  <= 16'h0000;
      dm_wdata_r <= 8'h00;
      pm_rd_r    <= 1'b0;
      pm_addr_r  <= 16'h0000;
      slp_r      <= 1'b0;
      wdr_r      <= 1'b0;
      brk_r      <= 1'b0;
    end else begin
      regs_r     <= regs_nxt;
      status_register_r     <= status_register_nxt;
      sp_r       <= sp_nxt;
      st_r       <= st_nxt;
      dst_r      <= dst_nxt;
      ldm_r      <= ldm_nxt;
      dm_rd_r    <= dm_rd_nxt;
      dm_wr_r    <= dm_wr_nxt;
      dm_addr_r  <= dm_addr_nxt;
      dm_wdata_r <= dm_wdata_nxt;
      pm_rd_r    <= pm_rd_nxt;
      pm_addr_r  <= pm_addr_nxt;
      slp_r      <= slp_nxt;
      wdr_r      <= wdr_nxt;
      brk_r      <= brk_nxt;
    end
  end

  // busy is registered: high in the cycles after a multi-cycle op is taken
  logic busy_r;
  always_ff @(posedge clock) begin
    if (!rstn) busy_r <= 1'b0;
    else       busy_r <= (st_nxt != cbx_pkg::CBX_S_IDLE);
  end

  assign busy            = busy_r;
  assign dm_rd           = dm_rd_r;
  assign dm_wr           = dm_wr_r;
  assign dm_addr         = dm_addr_r;
  assign dm_wdata        = dm_wdata_r;
  assign pm_rd           = pm_rd_r;
  assign pm_addr         = pm_addr_r;
  assign sleep_req       = slp_r;
  assign wdt_restart     = wdr_r;
  assign dbg_break       = brk_r;
  assign status_register = status_register_r;
  assign stack_ptr       = sp_r;

endmodule

`default_nettype wire

// ===== tb/cbx_exec_properties.sv
// Purpose: port-level timing and flag checks for the execution unit
// Assumes: one clock, synchronous active-low reset, decoder waits for busy low
// Notes:   register file contents are judged by the bench through stores
`timescale 1ns/1ps
`default_nettype none

module cbx_exec_properties (
  // clock, reset, decoded operation, memory buses and status
  input wire logic        clock, rstn, op_valid,
  input wire logic [5:0]  op_code, op_disp,
  input wire logic [4:0]  op_rd, op_rr,
  input wire logic [2:0]  op_bit,
  input wire logic [1:0]  op_ptr,
  input wire logic [15:0] op_addr, dm_addr, pm_addr, stack_ptr,
  input wire logic [7:0]  op_imm, dm_rdata, pm_rdata, dm_wdata, status_register,
  // strobes and control pulses
  input wire logic        dm_rd, dm_wr, pm_rd, busy, sleep_req, wdt_restart, dbg_break
);
  // ==========================================
  // helpers
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic tk;
  assign tk = op_valid && !busy;

  // ==========================================
  // assertions
  AST_ONE_CYCLE: assert property (tk && op_code <= cbx_pkg::CBX_LDI |=> !busy)
    else $error("one-cycle op raised busy");
  AST_NO_FLAGS: assert property (tk && op_code inside {cbx_pkg::CBX_SWAP, cbx_pkg::CBX_BLD,
    [cbx_pkg::CBX_MOV:cbx_pkg::CBX_LDI]} |=> $stable(status_register))
    else $error("flags moved on a flag-neutral op");
  AST_LOAD: assert property (tk && op_code inside {[cbx_pkg::CBX_LD_PTR:cbx_pkg::CBX_LD_DIR]}
    |=> busy && dm_rd && $stable(status_register) ##1 !busy && !dm_rd && $stable(status_register))
    else $error("load not two cycles");
  AST_STORE: assert property (tk && op_code inside {[cbx_pkg::CBX_ST_PTR:cbx_pkg::CBX_ST_DIR]}
    |=> dm_wr ##1 !dm_wr && !busy)
    else $error("store not two cycles");
  AST_PM: assert property (tk && op_code inside {[cbx_pkg::CBX_PM_R0:cbx_pkg::CBX_PM_INC]}
    |=> pm_rd && busy ##1 !pm_rd && busy ##1 !busy)
    else $error("program read not three cycles");
  AST_FLAG_SET: assert property (tk && op_code == cbx_pkg::CBX_FSET
    |=> status_register == ($past(status_register) | (8'h01 << $past(op_bit))))
    else $error("indexed set touched wrong flag");
  AST_PUSH: assert property (tk && op_code == cbx_pkg::CBX_PUSH
    |=> dm_wr && dm_addr == $past(stack_ptr) ##1 stack_ptr == $past(stack_ptr, 2) - 16'h0001)
    else $error("push address or stack pointer wrong");
  AST_POP: assert property (tk && op_code == cbx_pkg::CBX_POP
    |=> dm_rd && dm_addr == $past(stack_ptr) + 16'h0001 ##1 stack_ptr == dm_addr)
    else $error("pop address or stack pointer wrong");
  AST_SLEEP: assert property (tk && op_code == cbx_pkg::CBX_SLEEP |=> sleep_req && !busy ##1 !sleep_req)
    else $error("sleep pulse wrong");
  AST_WDR: assert property (tk && op_code == cbx_pkg::CBX_WDR |=> wdt_restart && !busy ##1 !wdt_restart)
    else $error("watchdog pulse wrong");
  AST_BREAK: assert property (dbg_break |-> $past(tk && op_code == cbx_pkg::CBX_BREAK))
    else $error("debug break without break op");

  // ==========================================
  // covers
  COV_PM: cover property (tk && op_code == cbx_pkg::CBX_PM_INC);
  COV_PUSH: cover property (tk && op_code == cbx_pkg::CBX_PUSH);
  COV_ROL: cover property (tk && op_code == cbx_pkg::CBX_ROL);
endmodule

`default_nettype wire

// ===== tb/cbx_mem_model.sv
// Purpose: data memory and program memory seen by the execution unit
// Assumes: data read answers while its strobe stands; flash answers the cycle after
// Notes:   only the low address byte selects data memory
`timescale 1ns/1ps
`default_nettype none

module cbx_mem_model (
  // clock and strobes
  input wire logic        clock,
  input wire logic        dm_rd,
  input wire logic        dm_wr,
  input wire logic        pm_rd,
  // addresses and data
  input wire logic [15:0] dm_addr,
  input wire logic [15:0] pm_addr,
  input wire logic [7:0]  dm_wdata,
  output logic     [7:0]  dm_rdata,
  output logic     [7:0]  pm_rdata
);
  // ==========================================
  // storage
  logic [7:0] mem_r [0:255];
  logic       pm_hold_r;
  // outside the strobe the data read shows the inverse, so a mistimed sample fails
  always_comb begin
    dm_rdata = dm_rd ? mem_r[dm_addr[7:0]] : ~mem_r[dm_addr[7:0]];
  end
  always_ff @(posedge clock) begin
    if (dm_wr) mem_r[dm_addr[7:0]] <= dm_wdata;
    pm_hold_r <= pm_rd;
    if (pm_rd) pm_rdata <= pm_addr[7:0] ^ 8'ha5;
    else if (!pm_hold_r) pm_rdata <= ~pm_rdata;
  end
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: directed test of the execution unit through its decoder port
// Assumes: register contents are read back with direct stores
// Notes:   op_rr follows op_rd except for CBX_MOV
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ==========================================
  // signals
  logic        clock, rstn, op_valid, dm_rd, dm_wr, pm_rd, busy, sleep_req, wdt_restart, dbg_break;
  logic [5:0]  op_code, op_disp;
  logic [4:0]  op_rd, op_rr;
  logic [2:0]  op_bit;
  logic [1:0]  op_ptr;
  logic [15:0] op_addr, dm_addr, pm_addr, stack_ptr;
  logic [7:0]  op_imm, dm_rdata, pm_rdata, dm_wdata, status_register, ex;
  int          n_mismatch, comparisons, cyc;

  cbx_exec DUT (.*);
  cbx_mem_model u_mem (.*);

  // ==========================================
  // tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // v carries immediate, bit index, and pointer select with displacement
  task automatic op(input logic [5:0] c, input logic [4:0] r, input logic [7:0] v);
    @(posedge clock);
    op_code <= c;
    op_rd <= r;
    op_rr <= (c == cbx_pkg::CBX_MOV) ? v[4:0] : r;
    op_imm <= v;
    op_bit <= v[2:0];
    op_ptr <= v[7:6];
    op_disp <= v[5:0];
    op_valid <= 1'b1;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    while (busy === 1'b1) @(posedge clock) #1;
  endtask

  task automatic peek(input logic [4:0] r, input logic [7:0] e);
    op_addr <= 16'h0040;
    op(cbx_pkg::CBX_ST_DIR, r, 8'h00);
    chk("st addr", dm_addr, 16'h0040);
    chk("reg", {8'h00, dm_wdata}, {8'h00, e});
  endtask

  task automatic sr(input logic [7:0] e);
    chk("status_register", {8'h00, status_register}, {8'h00, e});
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================
  // clock and timeout
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ==========================================
  // sequence
  initial begin
    {rstn, op_valid, op_code, op_rd, op_rr, op_bit, op_ptr, op_disp, op_addr, op_imm} = '0;
    ex = 8'h00;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    #1;
    sr(cbx_pkg::STATUS_REGISTER_RST);
    chk("sp", stack_ptr, cbx_pkg::SP_RST);
    for (int i = 0; i < 16; i++) begin
      op(i < 8 ? cbx_pkg::CBX_FSET : cbx_pkg::CBX_FCLR, 5'h00, 8'(i));
      ex = ex ^ (8'h01 << i[2:0]);
      sr(ex);
    end
    op(cbx_pkg::CBX_FSET, 5'h00, 8'h00);
    op(cbx_pkg::CBX_LDI, 5'h10, 8'h81);
    op(cbx_pkg::CBX_ROL, 5'h10, 8'h00);
    sr(8'h19);
    peek(5'h10, 8'h03);
    op(cbx_pkg::CBX_ROR, 5'h10, 8'h00);
    sr(8'h15);
    peek(5'h10, 8'h81);
    op(cbx_pkg::CBX_FCLR, 5'h00, 8'h00);
    op(cbx_pkg::CBX_ASR, 5'h10, 8'h00);
    sr(8'h15);
    peek(5'h10, 8'hc0);
    op(cbx_pkg::CBX_BST, 5'h10, 8'h07);
    sr(8'h55);
    op(cbx_pkg::CBX_LDI, 5'h11, 8'h00);
    op(cbx_pkg::CBX_BLD, 5'h11, 8'h00);
    sr(8'h55);
    peek(5'h11, 8'h01);
    op(cbx_pkg::CBX_MOV, 5'h12, 8'h10);
    peek(5'h12, 8'hc0);
    op(cbx_pkg::CBX_SWAP, 5'h10, 8'h00);
    sr(8'h55);
    peek(5'h10, 8'h0c);
    op(cbx_pkg::CBX_LDI, 5'h1a, 8'h10);
    op(cbx_pkg::CBX_LDI, 5'h1b, 8'h00);
    op(cbx_pkg::CBX_ST_INC, 5'h10, 8'h00);
    chk("st x+", dm_addr, 16'h0010);
    op(cbx_pkg::CBX_ST_PTR, 5'h11, 8'h00);
    chk("st x", dm_addr, 16'h0011);
    op(cbx_pkg::CBX_LD_DEC, 5'h13, 8'h00);
    chk("ld -x", dm_addr, 16'h0010);
    peek(5'h13, 8'h0c);
    op(cbx_pkg::CBX_LDI, 5'h1c, 8'h10);
    op(cbx_pkg::CBX_LDI, 5'h1d, 8'h00);
    op(cbx_pkg::CBX_LD_DISP, 5'h14, 8'h41);
    chk("ldd y", dm_addr, 16'h0011);
    peek(5'h14, 8'h01);
    op(cbx_pkg::CBX_LD_INC, 5'h15, 8'h40);
    chk("ld y+", dm_addr, 16'h0010);
    op(cbx_pkg::CBX_ST_DISP, 5'h15, 8'h40);
    chk("std y", dm_addr, 16'h0011);
    op(cbx_pkg::CBX_ST_DEC, 5'h15, 8'h40);
    chk("st -y", dm_addr, 16'h0010);
    op_addr <= 16'h0011;
    op(cbx_pkg::CBX_LD_DIR, 5'h16, 8'h00);
    peek(5'h16, 8'h0c);
    op(cbx_pkg::CBX_PUSH, 5'h10, 8'h00);
    chk("push addr", dm_addr, 16'h04ff);
    chk("push sp", stack_ptr, 16'h04fe);
    op(cbx_pkg::CBX_POP, 5'h17, 8'h00);
    chk("pop sp", stack_ptr, 16'h04ff);
    peek(5'h17, 8'h0c);
    op(cbx_pkg::CBX_LDI, 5'h1e, 8'h21);
    op(cbx_pkg::CBX_LDI, 5'h1f, 8'h00);
    op(cbx_pkg::CBX_PM_INC, 5'h18, 8'h00);
    chk("pm z+", pm_addr, 16'h0021);
    peek(5'h18, 8'h84);
    op(cbx_pkg::CBX_PM_R0, 5'h05, 8'h00);
    chk("pm z", pm_addr, 16'h0022);
    peek(5'h00, 8'h87);
    op(cbx_pkg::CBX_SLEEP, 5'h00, 8'h00);
    op(cbx_pkg::CBX_WDR, 5'h00, 8'h00);
    op(cbx_pkg::CBX_BREAK, 5'h00, 8'h00);
    sr(8'h55);
    print_verdict();
  end
endmodule

bind cbx_exec cbx_exec_properties u_prop (.*);

`default_nettype wire
